// [hw/wes_defs.svh]
// Constants for the wake event status and ready block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef WES_DEFS_SVH
`define WES_DEFS_SVH
`define WES_OFS_POWER_CTRL   8'h84
`define WES_OFS_BYTE_TEST    8'h64
`define WES_BIT_READY        0
`define WES_BIT_PIN_EN       1
`define WES_BIT_POL          2
`define WES_BIT_PULSE        3
`define WES_LSB_CAUSE        4
`define WES_MSB_CAUSE        5
`define WES_BIT_DRIVE        6
`define WES_BIT_ENERGY_DETECT_ENABLE        8
`define WES_BIT_WF_EN        9
`define WES_LSB_PSTATE       12
`define WES_MSB_PSTATE       13
`define WES_CAUSE_NONE       2'h0
`define WES_CAUSE_ENERGY     2'h1
`define WES_CAUSE_FRAME      2'h2
`define WES_CAUSE_MULTI      2'h3
`define WES_PULSE_MS         50
`define WES_CLK_MHZ          125
`define WES_PULSE_CYC        (`WES_PULSE_MS * 1000 * `WES_CLK_MHZ)
`define WES_SETTLE_CYC       64
`endif

// [hw/wes_pkg.sv]
// Types for the wake event status and ready block.
// Assumes wes_defs.svh is on the include path.
`include "wes_defs.svh"
package wes_pkg;
    typedef enum logic [1:0] {WES_FULL, WES_FRAME, WES_ENERGY, WES_RSVD} wes_pstate_e;
    typedef enum {WES_SETTLE, WES_READY, WES_ASLEEP} wes_rdy_e;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } wes_bus_s;
    typedef struct packed {
        logic energy;
        logic frame;
    } wes_evt_s;
endpackage

// [hw/wes_power_ctrl.sv]
// Power control register: wake cause, wake pin control and device ready flag.
// Assumes a synchronous SRAM-like bus, one cycle strobes, and event inputs as pulses.
`timescale 1ns/1ps
`include "wes_defs.svh"

// Overview of operation
// - Wake cause at bits 5-4: none, energy, frame, or multiple.
// - Writing one to a cause bit clears it; zero leaves it.
// - Cause clearing ignored unless full power state and ready.
// - Cause bit clears only when its event sources are clear.
// - Pulse select one drives pin active for 50 ms.
// - Pulse select zero holds pin active until deactivated.
// - Pin deactivates on cause clear or when both event enables clear.
// - Polarity bit 2 selects active high or active low.
// - Open-drain pin ignores polarity, always active low.
// - Pin enable bit 1 gates the pin; never asserts when zero.
// - Pin enable does not affect the internal wake interrupt.
// - Ready bit 0 sets only when stable after power-up or wake.
// - Power control register reads work in every state.
// - Power state field: full, frame wake, energy wake, reserved.
// - Drive type bit 6: zero open-drain, one push-pull.
// - Frame or energy enable raises internal wake interrupt on event.
// - Byte test write wakes device; host waits for ready.
module wes_power_ctrl #(
    parameter int PULSE_CYC  = `WES_PULSE_CYC,
    parameter int SETTLE_CYC = `WES_SETTLE_CYC
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire wes_pkg::wes_bus_s bus,
    output logic [31:0]           rdata,
    input  wire wes_pkg::wes_evt_s evt,
    input  wire wes_pkg::wes_evt_s evt_src_pend,
    output logic                  wake_event_irq,
    output logic                  wake_event_pin_o,
    output logic                  wake_event_pin_oe_n,
    output logic [1:0]            power_state_sel
);
    localparam int CW = $clog2(PULSE_CYC + 1);

    logic              ctl_wr;
    logic              wake_wr;
    logic [1:0]        cause_q,  cause_d;
    logic [1:0]        cause_new;
    logic [1:0]        src_pend;
    logic              pulse_q,  pulse_d;
    logic              pol_q,    pol_d;
    logic              pin_en_q, pin_en_d;
    logic              drive_q,  drive_d;
    logic              energy_detect_enable_q,  energy_detect_enable_d;
    logic              wf_en_q,  wf_en_d;
    logic [1:0]        pst_q,    pst_d;
    wes_pkg::wes_rdy_e rdy_q,    rdy_d;
    logic [15:0]       settle_q, settle_d;
    logic              act_q,    act_d;
    logic [CW-1:0]     pcnt_q,   pcnt_d;
    logic              irq_q,    irq_d;
    logic [31:0]       rdata_d;
    logic              ready;
    logic              hit;
    logic              pin_active;

    assign ctl_wr  = bus.wr && (bus.addr == `WES_OFS_POWER_CTRL);
    assign wake_wr = bus.wr && (bus.addr == `WES_OFS_BYTE_TEST);
    assign ready   = (rdy_q == wes_pkg::WES_READY);

    // Event detection filtered by the per-kind enables, pin enable not involved.
    always_comb
    begin
        // Pending sources in cause bit order: the packed struct puts energy at the top.
        src_pend = {evt_src_pend.frame, evt_src_pend.energy};
        cause_new[0] = evt.energy && energy_detect_enable_q;
        cause_new[1] = evt.frame && wf_en_q;
        hit = |cause_new;
    end

    always_comb
    begin
        cause_d  = cause_q;
        pulse_d  = pulse_q;
        pol_d    = pol_q;
        pin_en_d = pin_en_q;
        drive_d  = drive_q;
        energy_detect_enable_d  = energy_detect_enable_q;
        wf_en_d  = wf_en_q;
        pst_d    = pst_q;
        if (ctl_wr)
        begin
            pulse_d  = bus.wdata[`WES_BIT_PULSE];
            pol_d    = bus.wdata[`WES_BIT_POL];
            pin_en_d = bus.wdata[`WES_BIT_PIN_EN];
            drive_d  = bus.wdata[`WES_BIT_DRIVE];
            energy_detect_enable_d  = bus.wdata[`WES_BIT_ENERGY_DETECT_ENABLE];
            wf_en_d  = bus.wdata[`WES_BIT_WF_EN];
            if (bus.wdata[`WES_MSB_PSTATE:`WES_LSB_PSTATE] != 2'h3)
            begin
                pst_d = bus.wdata[`WES_MSB_PSTATE:`WES_LSB_PSTATE];
            end
            // clear only when ready at full power
            if (ready && (pst_q == 2'h0))
            begin
                for (int i = 0; i < 2; i++)
                begin
                    if (bus.wdata[`WES_LSB_CAUSE + i] && !src_pend[i])
                    begin
                        cause_d[i] = 1'b0;
                    end
                end
            end
        end
        // byte test write or enabled event returns to full power
        if ((wake_wr || hit) && (rdy_q == wes_pkg::WES_ASLEEP))
        begin
            pst_d = 2'h0;
        end
        if (hit)
        begin
            cause_d = cause_d | cause_new;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            cause_q  <= `WES_CAUSE_NONE;
            pulse_q  <= 1'b0;
            pol_q    <= 1'b0;
            pin_en_q <= 1'b0;
            drive_q  <= 1'b0;
            energy_detect_enable_q  <= 1'b0;
            wf_en_q  <= 1'b0;
            pst_q    <= 2'h0;
        end
        else
        begin
            cause_q  <= cause_d;
            pulse_q  <= pulse_d;
            pol_q    <= pol_d;
            pin_en_q <= pin_en_d;
            drive_q  <= drive_d;
            energy_detect_enable_q  <= energy_detect_enable_d;
            wf_en_q  <= wf_en_d;
            pst_q    <= pst_d;
        end
    end

    // ready after settle count following reset or wake
    always_comb
    begin
        rdy_d    = rdy_q;
        settle_d = settle_q;
        unique case (rdy_q)
            wes_pkg::WES_SETTLE:
            begin
                if (settle_q >= 16'(SETTLE_CYC - 1))
                begin
                    rdy_d    = wes_pkg::WES_READY;
                    settle_d = '0;
                end
                else
                begin
                    settle_d = settle_q + 16'h1;
                end
            end
            wes_pkg::WES_READY:
            begin
                if (pst_d != 2'h0)
                begin
                    rdy_d = wes_pkg::WES_ASLEEP;
                end
            end
            wes_pkg::WES_ASLEEP:
            begin
                if (pst_d == 2'h0 || hit)
                begin
                    rdy_d = wes_pkg::WES_SETTLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            rdy_q    <= wes_pkg::WES_SETTLE;
            settle_q <= '0;
        end
        else
        begin
            rdy_q    <= rdy_d;
            settle_q <= settle_d;
        end
    end

    // Pin activity and pulse timer on the free-running clock.
    always_comb
    begin
        act_d  = act_q;
        pcnt_d = pcnt_q;
        irq_d  = hit;
        if (hit)
        begin
            act_d  = 1'b1;
            pcnt_d = CW'(PULSE_CYC);
        end
        else if (pulse_q && act_q)
        begin
            if (pcnt_q <= CW'(1))
            begin
                act_d  = 1'b0;
                pcnt_d = '0;
            end
            else
            begin
                pcnt_d = pcnt_q - CW'(1);
            end
        end
        // deactivate on cause cleared or enables cleared
        if (!hit && ((cause_d == 2'h0) || !(energy_detect_enable_d || wf_en_d)))
        begin
            act_d = 1'b0;
        end
        // static mode holds act until deactivated
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            act_q  <= 1'b0;
            pcnt_q <= '0;
            irq_q  <= 1'b0;
        end
        else
        begin
            act_q  <= act_d;
            pcnt_q <= pcnt_d;
            irq_q  <= irq_d;
        end
    end

    assign wake_event_irq = irq_q;

    assign pin_active = act_q && pin_en_q;

    // drive type selects open-drain or push-pull
    // open-drain is active low regardless of polarity
    always_comb
    begin
        if (!drive_q)
        begin
            wake_event_pin_o    = 1'b0;
            wake_event_pin_oe_n = !pin_active;
        end
        else
        begin
            wake_event_pin_o    = pol_q ? pin_active : !pin_active;
            wake_event_pin_oe_n = 1'b0;
        end
    end

    assign power_state_sel = pst_q;

    // power control register readable in every state
    always_comb
    begin
        rdata_d = rdata;
        if (bus.rd)
        begin
            rdata_d = '0;
            if (bus.addr == `WES_OFS_POWER_CTRL)
            begin
                rdata_d[`WES_BIT_READY]                  = ready;
                rdata_d[`WES_BIT_PIN_EN]                 = pin_en_q;
                rdata_d[`WES_BIT_POL]                    = pol_q;
                rdata_d[`WES_BIT_PULSE]                  = pulse_q;
                rdata_d[`WES_MSB_CAUSE:`WES_LSB_CAUSE]   = cause_q;
                rdata_d[`WES_BIT_DRIVE]                  = drive_q;
                rdata_d[`WES_BIT_ENERGY_DETECT_ENABLE]                  = energy_detect_enable_q;
                rdata_d[`WES_BIT_WF_EN]                  = wf_en_q;
                rdata_d[`WES_MSB_PSTATE:`WES_LSB_PSTATE] = pst_q;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= rdata_d;
        end
    end

    ready_sleep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (pst_q != 2'h0) |-> !ready)
        else $error("ready set outside full power");
    pin_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !pin_en_q |-> (drive_q ? (wake_event_pin_o == !pol_q) : wake_event_pin_oe_n))
        else $error("wake pin active while disabled");
    od_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!drive_q && !wake_event_pin_oe_n) |-> !wake_event_pin_o)
        else $error("open-drain pin driven high");
    irq_raise_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (evt.frame && wf_en_q) |=> wake_event_irq)
        else $error("frame event missed interrupt");
    clr_block_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!ready && cause_q[0]) |=> cause_q[0])
        else $error("cause cleared while not ready");
    src_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (evt_src_pend.frame && cause_q[1]) |=> cause_q[1])
        else $error("cause cleared with source pending");
    multi_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cause_q == 2'h1 && evt.frame && wf_en_q) |=> (cause_q == 2'h3))
        else $error("second cause not merged");
    pulse_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        hit |=> act_q ##1 (act_q || !pulse_q || cause_q == 2'h0))
        else $error("pulse did not start");
    w1c_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ctl_wr && ready && pst_q == 2'h0 && bus.wdata[4] && !evt_src_pend.energy && !hit)
        |=> !cause_q[0])
        else $error("write one did not clear cause");
endmodule

// [bench/wes_host_model.sv]
// Host processor model that drives the register bus of the power control block.
// Assumes the bench calls its tasks and that strobes last one cycle from a falling edge.
`timescale 1ns/1ps
`include "wes_defs.svh"
module wes_host_model (
    input  wire logic         ref_clk,
    output wes_pkg::wes_bus_s bus,
    input  wire logic [31:0]  rdata
);
    initial bus = '0;

    // Released address and data show the inverse, so stale values are never reused.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk);
        bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge ref_clk);
        bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge ref_clk);
        bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hffffffff};
        @(negedge ref_clk);
        d = rdata;
    endtask

    task automatic wait_ready(output logic ok);
        logic [31:0] v;
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++)
        begin
            rd(`WES_OFS_POWER_CTRL, v);
            ok = (v[`WES_BIT_READY] === 1'b1);
        end
    endtask
endmodule

// [bench/wes_power_ctrl_tb.sv]
// Self-checking bench for the wake event status and ready block.
// Assumes the host model and the design are compiled before this file.
`timescale 1ns/1ps
`include "wes_defs.svh"
module wes_power_ctrl_tb;
    localparam int         PULSE = 20;
    localparam logic [7:0] PC    = `WES_OFS_POWER_CTRL;
    logic              ref_clk      = 1'b0;
    logic              reset_n      = 1'b0;
    wes_pkg::wes_bus_s bus;
    logic [31:0]       rdata;
    wes_pkg::wes_evt_s evt          = '0;
    wes_pkg::wes_evt_s evt_src_pend = '0;
    logic              irq;
    logic              pin_o;
    logic              pin_oe_n;
    logic [1:0]        pstate;
    logic [31:0]       v;
    logic              ok;
    int                err_total = 0;
    int                checked   = 0;
    int                cycles    = 0;
    int                n;

    always #4 ref_clk = ~ref_clk;

    wes_power_ctrl #(.PULSE_CYC(PULSE), .SETTLE_CYC(4)) dut (
        .ref_clk             (ref_clk),
        .reset_n             (reset_n),
        .bus                 (bus),
        .rdata               (rdata),
        .evt                 (evt),
        .evt_src_pend        (evt_src_pend),
        .wake_event_irq      (irq),
        .wake_event_pin_o    (pin_o),
        .wake_event_pin_oe_n (pin_oe_n),
        .power_state_sel     (pstate)
    );

    wes_host_model host (
        .ref_clk (ref_clk),
        .bus     (bus),
        .rdata   (rdata)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("counts: %0d compared, %0d mismatched", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_pin(input logic act, input logic pp, input logic pol);
        if (pp)
        begin
            check({31'h0, pin_oe_n}, 32'h0);
            check({31'h0, pin_o}, {31'h0, act ~^ pol});
        end
        else
        begin
            check({31'h0, pin_oe_n}, {31'h0, !act});
            if (act)
                check({31'h0, pin_o}, 32'h0);
        end
    endtask

    task automatic fire(input logic en, input logic fr);
        @(negedge ref_clk);
        evt = '{energy: en, frame: fr};
        @(negedge ref_clk);
        evt = '0;
        check({31'h0, irq}, 32'h1);
    endtask

    task automatic cause(input logic [31:0] exp);
        host.rd(PC, v);
        check(v & 32'h30, exp);
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            complete_run();
        end
    end

    initial
    begin
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        host.rd(PC, v);
        check(v & 32'h1, 32'h0);
        check({31'h0, pin_oe_n}, 32'h1);
        host.wait_ready(ok);
        check({31'h0, ok}, 32'h1);
        host.wr(PC, 32'h3000);
        check({30'h0, pstate}, 32'h0);
        $display("test reset done");
        host.wr(PC, 32'h346);
        fire(1'b0, 1'b1);
        cause(32'h20);
        chk_pin(1'b1, 1'b1, 1'b1);
        repeat (2 * PULSE) @(negedge ref_clk);
        chk_pin(1'b1, 1'b1, 1'b1);
        fire(1'b1, 1'b0);
        cause(32'h30);
        evt_src_pend.frame = 1'b1;
        host.wr(PC, 32'h376);
        cause(32'h20);
        evt_src_pend = '0;
        host.wr(PC, 32'h366);
        cause(32'h0);
        chk_pin(1'b0, 1'b1, 1'b1);
        $display("test cause done");
        host.wr(PC, 32'h344);
        fire(1'b1, 1'b0);
        cause(32'h10);
        chk_pin(1'b0, 1'b1, 1'b1);
        host.wr(PC, 32'h354);
        host.wr(PC, 32'h206);
        fire(1'b0, 1'b1);
        chk_pin(1'b1, 1'b0, 1'b1);
        host.wr(PC, 32'h006);
        chk_pin(1'b0, 1'b0, 1'b1);
        host.wr(PC, 32'h026);
        $display("test pin done");
        host.wr(PC, 32'h34e);
        fire(1'b0, 1'b1);
        n = 1;
        while (pin_o === 1'b1 && n < 3 * PULSE)
        begin
            @(negedge ref_clk);
            n++;
        end
        check({31'h0, n >= PULSE - 1 && n <= PULSE + 1}, 32'h1);
        host.wr(PC, 32'h36e);
        $display("test pulse done");
        host.wr(PC, 32'h1000);
        host.rd(PC, v);
        check(v & 32'h1, 32'h0);
        check({30'h0, pstate}, 32'h1);
        host.wr(`WES_OFS_BYTE_TEST, 32'h0);
        host.wait_ready(ok);
        check({31'h0, ok}, 32'h1);
        host.wr(PC, 32'h1100);
        fire(1'b1, 1'b0);
        host.wait_ready(ok);
        check({31'h0, ok}, 32'h1);
        check({30'h0, pstate}, 32'h0);
        cause(32'h10);
        $display("test sleep done");
        complete_run();
    end
endmodule
